// ### core/rtcfc_map.svh
// register map, field positions, reset values and timing counts
`ifndef RTCFC_MAP_SVH
`define RTCFC_MAP_SVH
`define RTCFC_IDX_EXT 5'h0d
`define RTCFC_IDX_FLAG 5'h0e
`define RTCFC_IDX_CTRL 5'h0f
`define RTCFC_IDX_EXT_ALT 5'h1d
`define RTCFC_IDX_FLAG_ALT 5'h1e
`define RTCFC_IDX_CTRL_ALT 5'h1f
`define RTCFC_IDX_CNT_LO 5'h10
`define RTCFC_IDX_CNT_HI 5'h11
`define RTCFC_EXT_TEST 7
`define RTCFC_EXT_ALARM_SEL 6
`define RTCFC_EXT_UPD_SEL 5
`define RTCFC_EXT_RUN 4
`define RTCFC_FLG_UPD 5
`define RTCFC_FLG_CNT 4
`define RTCFC_FLG_ALM 3
`define RTCFC_FLG_LOSS 1
`define RTCFC_FLG_COMP 0
`define RTCFC_CTL_UIE 5
`define RTCFC_CTL_TIE 4
`define RTCFC_CTL_AIE 3
`define RTCFC_CTL_RST 0
`define RTCFC_EXT_RESET 8'h00
`define RTCFC_FLAG_RESET 8'h03
`define RTCFC_CTRL_RESET 8'h40
`define RTCFC_FLAG_MASK 8'h3b
`define RTCFC_CTRL_MASK 8'hf9
`define RTCFC_CLK_HZ 20000000
`define RTCFC_OSC_HZ 32768
`define RTCFC_RTN_SEC_MS 500
`define RTCFC_RTN_MIN_US 7813
`define RTCFC_RTN_SEC_TICKS ((`RTCFC_RTN_SEC_MS * `RTCFC_OSC_HZ) / 1000)
`define RTCFC_RTN_MIN_TICKS ((`RTCFC_RTN_MIN_US * `RTCFC_OSC_HZ) / 1000000)
`endif

// ### core/rtcfc_pkg.sv
// types shared by the flag/control register block
package rtcfc_pkg;
	typedef enum logic [1:0] {
		RTCFC_BUS_IDLE,
		RTCFC_BUS_ACK
	} rtcfc_bus_t;
	typedef struct packed {
		logic [31:0] acc;
		logic tick;
	} rtcfc_div_state_t;
endpackage

// ### core/rtcfc_regs.sv
// extension, flag and control registers with timer, update and alarm
`timescale 1ns/1ps
`include "rtcfc_map.svh"
// Function
// R1: host keeps test bit zero always
// R2: alarm select one day, zero week
// R3: update select zero second, one minute
// R4: update irq returns 500ms or 7.813ms
// R5: run bit starts or stops countdown
// R6: clkout 32768/1024/1/32768 Hz by select
// R7: countdown clocks 4096/64 Hz, second, minute
// R8: update flag sticky until zero written
// R9: countdown flag sticky until zero written
// R10: alarm flag sticky until zero written
// R11: data loss flag sticky, set at reset
// R12: comp stop flag sticky, set at reset
// R13: host reinitialises after data loss
// R14: unused flag and control bits read zero
// R15: comp interval 0.5/2/10/30 s select
// R16: reset values of test, select, flags
// R17: irq low, OR of enabled requests
// R18: reset bit clears prescaler, stops clock
// R19: countdown event on 001h to 000h
// R20: alarm event on qualified time match
// R21: both aliases reach same storage
module rtcfc_regs
	import rtcfc_pkg::*;
#(
	parameter int CLK_HZ = `RTCFC_CLK_HZ
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic second_tick_i,
	input wire logic minute_tick_i,
	input wire logic day_match_i,
	input wire logic week_match_i,
	input wire logic time_match_i,
	input wire logic data_loss_i,
	input wire logic comp_stop_i,
	output logic clock_output_pin_o,
	output logic irq_n_o,
	output logic [1:0] comp_interval_o,
	output logic prescale_clear_o
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		rtcfc_bus_t bus;
		logic [31:0] rdat;
		logic [7:0] ext;
		logic [7:0] flg;
		logic [7:0] ctl;
		logic [11:0] preset;
		logic [11:0] count;
		logic [14:0] pre;
		logic [14:0] rtn;
		logic upd_req;
		logic cnt_req;
		logic clock_output_pin;
		logic [15:0] half;
		logic irq_n;
		logic [2:0] sync_a;
		logic [2:0] sync_b;
		logic [2:0] lvl;
		logic [3:0] sync_ca;
		logic [3:0] sync_cb;
		logic match_d;
	} rtcfc_regs_t;
	rtcfc_regs_t st;
	rtcfc_regs_t next_st;
	logic osc_tick;
	// clock cycles in half an oscillator period, for the fast output
	localparam int HALF_CYC = CLK_HZ / (2 * `RTCFC_OSC_HZ);

	// oscillator tick source, frozen while the reset bit is set
	rtcfc_tick_div #(.CLK_HZ(CLK_HZ), .OSC_HZ(`RTCFC_OSC_HZ)) u_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.hold_i(st.ctl[`RTCFC_CTL_RST]),
		.tick_o(osc_tick)
	);

	// ----------------------------------------------------------------
	// register index decode
	// ----------------------------------------------------------------
	// index decode shared by read and write
	function automatic logic [1:0] rtcfc_decode(input logic [4:0] idx);
		logic [1:0] sel;
		sel = 2'd3;
		if (idx == `RTCFC_IDX_EXT || idx == `RTCFC_IDX_EXT_ALT) begin
			sel = 2'd0; // [R21]
		end else if (idx == `RTCFC_IDX_FLAG || idx == `RTCFC_IDX_FLAG_ALT) begin
			sel = 2'd1; // [R21]
		end else if (idx == `RTCFC_IDX_CTRL || idx == `RTCFC_IDX_CTRL_ALT) begin
			sel = 2'd2; // [R21]
		end
		return sel;
	endfunction

	// decoded request and event strobes
	logic [4:0] idx;
	logic [1:0] rsel;
	logic wr;
	logic [7:0] wd;
	logic sec_ev;
	logic min_ev;
	logic match_lvl;
	logic upd_ev;
	logic src_ev;
	logic alm_ev;
	logic cnt_ev;
	logic [14:0] pre_inc;
	assign idx = wb_adr_i[6:2];
	assign rsel = rtcfc_decode(idx);
	assign wd = wb_dat_i[7:0];
	assign pre_inc = st.pre + 15'h1;
	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] &&
			st.bus == RTCFC_BUS_IDLE;

		// --------------------------------------------------------
		// pin synchronisers and edge detection
		// --------------------------------------------------------
		// pin inputs: three flip-flops, edge from the second and third
		next_st.sync_a = {minute_tick_i, second_tick_i, data_loss_i};
		next_st.sync_b = st.sync_a;
		next_st.lvl = st.sync_b;
		// match levels share one delay, so they stay aligned
		next_st.sync_ca = {comp_stop_i, time_match_i, week_match_i,
			day_match_i};
		next_st.sync_cb = st.sync_ca;
		sec_ev = st.sync_b[1] && !st.lvl[1];
		min_ev = st.sync_b[2] && !st.lvl[2];

		// --------------------------------------------------------
		// update and alarm events
		// --------------------------------------------------------
		// alarm target select: day or week match
		match_lvl = st.sync_cb[2] && (st.ext[`RTCFC_EXT_ALARM_SEL] ?
			st.sync_cb[0] : st.sync_cb[1]); // [R2]
		next_st.match_d = match_lvl;
		// rising edge only, a held match raises the flag once
		alm_ev = match_lvl && !st.match_d; // [R20]
		upd_ev = st.ext[`RTCFC_EXT_UPD_SEL] ? min_ev : sec_ev; // [R3]

		// --------------------------------------------------------
		// prescaler, clock output and countdown
		// --------------------------------------------------------
		// oscillator prescaler, cleared by the reset bit
		if (st.ctl[`RTCFC_CTL_RST]) begin
			next_st.pre = 15'h0; // [R18]
		end else if (osc_tick) begin
			next_st.pre = pre_inc;
		end

		// countdown source select
		unique case (st.ext[1:0])
			2'b00: src_ev = osc_tick && pre_inc[2:0] == 3'h0; // [R7]
			2'b01: src_ev = osc_tick && pre_inc[8:0] == 9'h0; // [R7]
			2'b10: src_ev = sec_ev; // [R7]
			2'b11: src_ev = min_ev; // [R7]
		endcase

		// cycles since the last oscillator tick, saturating
		if (osc_tick) begin
			next_st.half = 16'h0;
		end else if (st.half != 16'hffff) begin
			next_st.half = st.half + 16'h1;
		end
		// clock output select; fast output high for half a period
		unique case (st.ext[3:2])
			2'b01: next_st.clock_output_pin = st.pre[4]; // [R6]
			2'b10: next_st.clock_output_pin = st.pre[14]; // [R6]
			default: next_st.clock_output_pin = osc_tick ||
				st.half < 16'(HALF_CYC - 1); // [R6]
		endcase

		// countdown: reload while stopped, event on a source tick at 001h, which reloads the preset
		cnt_ev = 1'b0;
		if (!st.ext[`RTCFC_EXT_RUN]) begin
			next_st.count = st.preset; // [R5]
		end else if (src_ev) begin
			if (st.count == 12'h001) begin
				cnt_ev = 1'b1; // [R19]
				next_st.count = st.preset;
			end else if (st.count != 12'h000) begin
				next_st.count = st.count - 12'h1; // [R5]
			end
		end

		// --------------------------------------------------------
		// flag and configuration writes
		// --------------------------------------------------------
		// flag clears by writing zero; writing one leaves them alone
		if (wr && rsel == 2'd1) begin
			next_st.flg = st.flg & wd & `RTCFC_FLAG_MASK; // [R14]
		end
		// sticky sets win over same-cycle clears
		if (upd_ev) next_st.flg[`RTCFC_FLG_UPD] = 1'b1; // [R8]
		if (cnt_ev) next_st.flg[`RTCFC_FLG_CNT] = 1'b1; // [R9]
		if (alm_ev) next_st.flg[`RTCFC_FLG_ALM] = 1'b1; // [R10]
		if (st.sync_b[0]) next_st.flg[`RTCFC_FLG_LOSS] = 1'b1; // [R11]
		if (st.sync_cb[3]) next_st.flg[`RTCFC_FLG_COMP] = 1'b1; // [R12]
		// configuration writes land on the taken edge
		if (wr && rsel == 2'd0) begin
			next_st.ext = wd;
		end
		if (wr && rsel == 2'd2) begin
			next_st.ctl = wd & `RTCFC_CTRL_MASK; // [R14]
		end
		if (wr && idx == `RTCFC_IDX_CNT_LO) begin
			next_st.preset[7:0] = wd;
		end
		if (wr && idx == `RTCFC_IDX_CNT_HI) begin
			next_st.preset[11:8] = wd[3:0];
		end

		// --------------------------------------------------------
		// interrupt requests
		// --------------------------------------------------------
		// update and countdown requests auto-return after a hold time
		if (upd_ev) begin
			next_st.upd_req = 1'b1;
			next_st.cnt_req = 1'b0;
			next_st.rtn = st.ext[`RTCFC_EXT_UPD_SEL] ?
				15'(`RTCFC_RTN_MIN_TICKS) : 15'(`RTCFC_RTN_SEC_TICKS); // [R4]
		end else if (cnt_ev) begin
			next_st.cnt_req = 1'b1;
			next_st.upd_req = 1'b0;
			next_st.rtn = 15'(`RTCFC_RTN_MIN_TICKS);
		end else if (osc_tick && st.rtn != 15'h0) begin
			next_st.rtn = st.rtn - 15'h1;
			if (st.rtn == 15'h1) begin
				next_st.upd_req = 1'b0; // [R4]
				next_st.cnt_req = 1'b0;
			end
		end
		// active-low interrupt, OR of enabled requests
		next_st.irq_n = !((next_st.upd_req && st.ctl[`RTCFC_CTL_UIE]) ||
			(next_st.cnt_req && st.ctl[`RTCFC_CTL_TIE]) ||
			(next_st.flg[`RTCFC_FLG_ALM] &&
			st.ctl[`RTCFC_CTL_AIE])); // [R17]

		// --------------------------------------------------------
		// bus answer
		// --------------------------------------------------------
		// ack one cycle after request, then drop
		unique case (st.bus)
			RTCFC_BUS_IDLE: begin
				if (wb_cyc_i && wb_stb_i) begin
					next_st.bus = RTCFC_BUS_ACK;
					unique case (rsel)
						2'd0: next_st.rdat = {24'h0, st.ext};
						2'd1: next_st.rdat = {24'h0, st.flg}; // [R14]
						2'd2: next_st.rdat = {24'h0, st.ctl}; // [R14]
						default: next_st.rdat = 32'h0;
					endcase
				end
			end
			RTCFC_BUS_ACK: begin
				next_st.bus = RTCFC_BUS_IDLE;
				next_st.rdat = 32'h0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
			st.ext <= `RTCFC_EXT_RESET; // [R16]
			st.flg <= `RTCFC_FLAG_RESET; // [R16]
			st.ctl <= `RTCFC_CTRL_RESET;
			st.irq_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// outputs straight from flip-flops
	assign wb_dat_o = st.rdat;
	assign wb_ack_o = st.bus == RTCFC_BUS_ACK;
	assign clock_output_pin_o = st.clock_output_pin;
	assign irq_n_o = st.irq_n;
	assign comp_interval_o = st.ctl[7:6]; // [R15]
	assign prescale_clear_o = st.ctl[`RTCFC_CTL_RST];
endmodule

// ### core/rtcfc_tick_div.sv
// oscillator tick generator from the system clock
`timescale 1ns/1ps
module rtcfc_tick_div
	import rtcfc_pkg::*;
#(
	parameter int CLK_HZ = 20000000,
	parameter int OSC_HZ = 32768
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic hold_i,
	output logic tick_o
);
	// ----------------------------------------------------------------
	// fractional accumulator, one tick per oscillator period
	// ----------------------------------------------------------------
	rtcfc_div_state_t st;
	rtcfc_div_state_t next_st;
	always_comb begin
		next_st.acc = st.acc + 32'(OSC_HZ);
		next_st.tick = 1'b0;
		if (hold_i) begin
			next_st.acc = st.acc;
		end else if (next_st.acc >= 32'(CLK_HZ)) begin
			next_st.acc = next_st.acc - 32'(CLK_HZ);
			next_st.tick = 1'b1;
		end
	end
	// accumulator and tick pulse registered together
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign tick_o = st.tick;
endmodule

// ### dv/rtcfc_host.sv
// host bus master model for the register block
`timescale 1ns/1ps
module rtcfc_host (
	input wire logic clk_i,
	input wire logic ack_i,
	output logic cyc_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [31:0] dat_o
);
	// idle bus from time zero
	initial begin
		cyc_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'h00;
		dat_o = 32'h0;
	end
	// one classic cycle, held until ack, then one idle cycle
	task automatic xfer(input logic w, input logic [4:0] i,
		input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (i[3:0] == 4'hd) v[7] = 1'b0;
		cyc_o <= 1'b1;
		we_o <= w;
		adr_o <= {1'b0, i, 2'b00};
		dat_o <= {24'h0, v};
		@(posedge clk_i);
		while (!ack_i) @(posedge clk_i);
		cyc_o <= 1'b0;
		we_o <= 1'b0;
		@(posedge clk_i);
	endtask
endmodule

// ### dv/rtcfc_regs_monitor.sv
// bus and output timing assertions for the register block
`timescale 1ns/1ps
module rtcfc_regs_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic irq_n_o,
	input wire logic [1:0] comp_interval_o,
	input wire logic prescale_clear_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// a request raised after an idle cycle
	sequence req_start;
		$rose(wb_cyc_i && wb_stb_i);
	endsequence
	// a read answer in progress
	sequence rd_ans;
		wb_ack_o && !wb_we_i;
	endsequence
	chk_ack_exact: assert property (req_start |=> wb_ack_o)
		else $error("ack missing after request");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i))
		else $error("ack without request");
	chk_flag_zero: assert property (rd_ans ##0 wb_adr_i[5:2] == 4'he
		|-> (wb_dat_o & 32'hffffffc4) == 32'h0)
		else $error("flag unused bits set");
	chk_ctrl_zero: assert property (rd_ans ##0 wb_adr_i[5:2] == 4'hf
		|-> (wb_dat_o & 32'hffffff06) == 32'h0)
		else $error("control unused bits set");
	chk_reset_vals: assert property ($fell(rst_i) |-> irq_n_o &&
		comp_interval_o == 2'b01 && !prescale_clear_o)
		else $error("bad outputs after reset");
	chk_comp_cause: assert property ($changed(comp_interval_o)
		|-> wb_ack_o || $past(wb_ack_o))
		else $error("interval changed without write");
	chk_clear_cause: assert property ($changed(prescale_clear_o)
		|-> wb_ack_o || $past(wb_ack_o))
		else $error("prescaler clear changed without write");
endmodule
bind rtcfc_regs rtcfc_regs_monitor u_rtcfc_regs_monitor (.clk_i(clk_i),
	.rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .irq_n_o(irq_n_o),
	.comp_interval_o(comp_interval_o),
	.prescale_clear_o(prescale_clear_o));

// ### dv/rtcfc_regs_tb.sv
// self-checking bench for the register block
`timescale 1ns/1ps
module rtcfc_regs_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [6:0] ev = 7'h00;
	logic cyc, we, ack, pin, irq_n, pclr, pin_d;
	logic [7:0] adr, r;
	logic [31:0] wdat, rdat;
	logic [1:0] cint;
	logic [7:0] expq[$];
	int fails = 0;
	int compares = 0;
	int cycles = 0;
	int k;
	int n;
	always #25 clk_i = ~clk_i;
	rtcfc_host u_rtcfc_host (.clk_i(clk_i), .ack_i(ack), .cyc_o(cyc),
		.we_o(we), .adr_o(adr), .dat_o(wdat));
	rtcfc_regs u_rtcfc_regs (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.second_tick_i(ev[0]), .minute_tick_i(ev[1]), .day_match_i(ev[2]),
		.week_match_i(ev[3]), .time_match_i(ev[4]), .data_loss_i(ev[5]),
		.comp_stop_i(ev[6]), .clock_output_pin_o(pin), .irq_n_o(irq_n),
		.comp_interval_o(cint), .prescale_clear_o(pclr));
	task automatic cmp(input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic wr(input logic [4:0] i, input logic [7:0] d);
		u_rtcfc_host.xfer(1'b1, i, d);
	endtask
	task automatic rd(input logic [4:0] i, input logic [7:0] e);
		expq.push_back(e);
		u_rtcfc_host.xfer(1'b0, i, 8'h00);
	endtask
	task automatic pulse(input int b);
		ev[b] <= 1'b1;
		repeat (4) @(posedge clk_i);
		ev[b] <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic results;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// read answers against oldest note
	always @(posedge clk_i) begin
		if (ack && !we) cmp({24'h0, expq.pop_front()}, rdat);
	end
	// hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 40000) begin
			fails++;
			results();
		end
	end
	initial begin
		void'($urandom(9));
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		for (k = 0; k < 2; k++) begin
			rd({k[0], 4'hd}, 8'h00);
			rd({k[0], 4'he}, 8'h03);
			rd({k[0], 4'hf}, 8'h40);
		end
		wr(5'h0e, 8'hff);
		rd(5'h1e, 8'h03);
		wr(5'h1e, 8'h00);
		rd(5'h0e, 8'h00);
		rd(5'h02, 8'h00);
		$display("test flags done");
		r = 8'($urandom);
		wr(5'h1f, r);
		rd(5'h0f, r & 8'hf9);
		cmp({30'h0, r[7:6]}, {30'h0, cint});
		cmp({31'h0, r[0]}, {31'h0, pclr});
		wr(5'h0f, 8'h20);
		pulse(0);
		rd(5'h0e, 8'h20);
		cmp(32'h0, {31'h0, irq_n});
		wr(5'h0f, 8'h00);
		cmp(32'h1, {31'h0, irq_n});
		wr(5'h0e, 8'h00);
		wr(5'h0d, 8'ha0);
		pulse(0);
		rd(5'h0e, 8'h00);
		pulse(1);
		rd(5'h0e, 8'h20);
		$display("test update done");
		wr(5'h0e, 8'h00);
		wr(5'h0d, 8'h00);
		ev[3] <= 1'b1;
		pulse(4);
		rd(5'h0e, 8'h08);
		wr(5'h0e, 8'h00);
		wr(5'h0d, 8'h40);
		pulse(4);
		rd(5'h0e, 8'h00);
		ev[2] <= 1'b1;
		pulse(4);
		rd(5'h0e, 8'h08);
		ev[3] <= 1'b0;
		ev[2] <= 1'b0;
		wr(5'h0e, 8'h00);
		$display("test alarm done");
		wr(5'h10, 8'h01);
		wr(5'h11, 8'h00);
		wr(5'h0d, 8'h10);
		repeat (12000) @(posedge clk_i);
		rd(5'h0e, 8'h10);
		pulse(5);
		pulse(6);
		rd(5'h0e, 8'h13);
		$display("test countdown done");
		// data loss seen: bring extension, control and flag registers back to a known state
		wr(5'h0d, 8'h00);
		wr(5'h0f, 8'h40);
		wr(5'h0e, 8'h00);
		rd(5'h1e, 8'h00);
		// fast output: about ten rises in 6100 cycles at 32768 Hz
		pin_d = pin;
		n = 0;
		repeat (6100) begin
			@(posedge clk_i);
			if (pin && !pin_d) n++;
			pin_d = pin;
		end
		cmp(32'h1, {31'h0, n >= 9 && n <= 10});
		$display("test clock output done");
		results();
	end
endmodule
